// *** verilog/game_clock_timers.sv ***
// Operation
// [RULE1] Setting holds game structure: two halves or four quarters.
// [RULE2] Count-down: load length, decrement, halt at zero.
// [RULE3] Count-up: load zero, increment, halt at selected length.
// [RULE4] Tenths shown when enabled, counting down, under one minute.
// [RULE5] Period load advances period number only if clock was zero.
// [RULE6] Stored break length used as main clock length between periods.
// [RULE7] Stored overtime length used for overtime periods.
// [RULE8] Two shot presets; remote reset buttons load shot clock from them.
// [RULE9] Preset edit shows stored value until first digit entered.
// [RULE10] Sync mode: main stop halts shot clock, main start restarts it.
// [RULE11] Independent mode: shot clock follows only remote run switch.
// [RULE12] Auto-blank: shot not below main blanks, resets, stops shot.
// [RULE13] Per-team time-out counts; zero count disables that team key.
// [RULE14] On/off key: zero duration disables that time-out type.
// [RULE15] Operator refills overtime time-out counts; hardware never refills.
// [RULE16] Full time-out duration starts full time-out countdown.
// [RULE17] Full warning value sounds one-second horn; zero disables.
// [RULE18] Partial time-out duration starts partial time-out countdown.
// [RULE19] Partial warning value sounds one-second horn; zero disables.
// [RULE20] Show-on-main routes time-out countdown to scoreboard digits.
// [RULE21] All clocks step on common tenth tick; times held as tenths.
// [RULE22] Time-out counts down to zero and stops; start uses one count.
`timescale 1ns/100ps
`include "game_clock_cfg.svh"
`default_nettype none
module game_clock_timers #(
   parameter int TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          remote_reset1,
   input  wire logic          remote_reset2,
   input  wire logic          remote_run,
   output logic      [15:0]   main_digits,
   output logic               main_tenths,
   output logic      [3:0]    period_num,
   output logic               game_quarters,
   output logic      [15:0]   shot_digits,
   output logic               shot_blank,
   output logic               shot_horn,
   output logic      [15:0]   timeout_digits,
   output logic               timeout_horn,
   output logic      [15:0]   lcd_value
);
   localparam int HORN_TICKS = `HORN_TIME_NS / `TICK_TIME_NS;

   logic [23:0]              tick_cnt;
   logic                     tick;
   logic [5:0]               ctrl;
   logic [`CMD_W-1:0]        cmd;
   game_clock_pkg::time_t    period_len;
   game_clock_pkg::time_t    break_len;
   game_clock_pkg::time_t    ot_len;
   game_clock_pkg::time_t    preset [2];
   game_clock_pkg::time_t    full_len;
   game_clock_pkg::time_t    full_warn;
   game_clock_pkg::time_t    part_len;
   game_clock_pkg::time_t    partial_pause_alert_time;
   game_clock_pkg::time_t    edit_buf;
   logic                     edit_active;
   logic                     edit_sel;
   logic                     digit_seen;
   logic [7:0]               to_count [4];
   game_clock_pkg::time_t    main_time;
   game_clock_pkg::time_t    main_limit;
   logic                     main_run;
   game_clock_pkg::time_t    shot_time;
   logic                     shot_run;
   game_clock_pkg::time_t    to_time;
   game_clock_pkg::to_state_e to_state;
   logic [7:0]               shot_horn_cnt;
   logic [7:0]               to_horn_cnt;
   logic                     setup;
   logic                     wr_en;
   logic [31:0]              rd_word;
   game_clock_pkg::time_t    ld_len;
   logic                     ld_any;
   logic                     main_done;
   logic                     blank_cond;
   logic                     to_active;
   logic                     to_key;
   logic [1:0]               to_idx;
   game_clock_pkg::time_t    to_dur;
   game_clock_pkg::time_t    to_warn;

   pin_sync_if #(.W(3)) rs ();
   assign rs.raw = {remote_run, remote_reset2, remote_reset1};

   pin_sync #(.W(3)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .ps    (rs)
   );

   function automatic logic reg_known(input logic [7:0] a);
      return (a <= `REG_EDIT) && (a[1:0] == 2'b00);
   endfunction

   // Tenth-second tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else if (tick_cnt == 24'(TICK_CYCLES - 1)) begin // [RULE21]
         tick_cnt <= '0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 24'h000001;
         tick     <= 1'b0;
      end
   end

   // APB slave: no wait state, answer in first access cycle
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite & reg_known(paddr);

   always_comb begin
      rd_word = '0;
      if (paddr == `REG_CTRL) begin
         rd_word = {26'h0, ctrl};
      end else if (paddr == `REG_PERIOD) begin
         rd_word = {16'h0, period_len};
      end else if (paddr == `REG_BREAK) begin
         rd_word = {16'h0, break_len};
      end else if (paddr == `REG_OVERTIME) begin
         rd_word = {16'h0, ot_len};
      end else if (paddr == `REG_SHOT1) begin
         rd_word = {16'h0, preset[0]};
      end else if (paddr == `REG_SHOT2) begin
         rd_word = {16'h0, preset[1]};
      end else if (paddr == `REG_FULL_LEN) begin
         rd_word = {16'h0, full_len};
      end else if (paddr == `REG_FULL_WARN) begin
         rd_word = {16'h0, full_warn};
      end else if (paddr == `REG_PART_LEN) begin
         rd_word = {16'h0, part_len};
      end else if (paddr == `REG_PART_WARN) begin
         rd_word = {16'h0, partial_pause_alert_time};
      end else if (paddr == `REG_TO_COUNTS) begin
         rd_word = {to_count[3], to_count[2], to_count[1], to_count[0]};
      end else if (paddr == `REG_MAIN_STAT) begin
         rd_word = {7'h0, main_run, 4'h0, period_num, main_time};
      end else if (paddr == `REG_SHOT_STAT) begin
         rd_word = {14'h0, blank_cond, shot_run, shot_time};
      end else if (paddr == `REG_TO_STAT) begin
         rd_word = {13'h0, to_state, to_time};
      end else if (paddr == `REG_EDIT) begin
         rd_word = {13'h0, digit_seen, edit_sel, edit_active, edit_buf};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~reg_known(paddr);
         if (setup) begin
            prdata  <= reg_known(paddr) ? rd_word : 32'h00000000;
         end
      end
   end

   // Settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl       <= `RST_CTRL;
         period_len <= `RST_TIME;
         break_len  <= `RST_TIME;
         ot_len     <= `RST_TIME;
         full_len   <= `RST_TIME;
         full_warn  <= `RST_TIME;
         part_len   <= `RST_TIME;
         partial_pause_alert_time <= `RST_TIME;
      end else if (wr_en) begin
         if (paddr == `REG_CTRL) begin
            ctrl <= pwdata[5:0]; // [RULE1]
         end else if (paddr == `REG_PERIOD) begin
            period_len <= pwdata[15:0];
         end else if (paddr == `REG_BREAK) begin
            break_len <= pwdata[15:0]; // [RULE6]
         end else if (paddr == `REG_OVERTIME) begin
            ot_len <= pwdata[15:0]; // [RULE7]
         end else if (paddr == `REG_FULL_LEN) begin
            full_len <= pwdata[15:0]; // [RULE16]
         end else if (paddr == `REG_FULL_WARN) begin
            full_warn <= pwdata[15:0];
         end else if (paddr == `REG_PART_LEN) begin
            part_len <= pwdata[15:0]; // [RULE18]
         end else if (paddr == `REG_PART_WARN) begin
            partial_pause_alert_time <= pwdata[15:0];
         end
      end
   end

   // Keypad command strobes, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= '0;
      end else begin
         cmd <= (wr_en && paddr == `REG_CMD) ? pwdata[`CMD_W-1:0] : '0;
      end
   end

   // Shot preset storage and edit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preset[0]   <= `RST_TIME;
         preset[1]   <= `RST_TIME;
         edit_buf    <= `RST_TIME;
         edit_active <= 1'b0;
         edit_sel    <= 1'b0;
         digit_seen  <= 1'b0;
      end else if (cmd[`CMD_EDIT_BEGIN]) begin
         edit_active <= 1'b1;
         edit_sel    <= cmd[`CMD_EDIT_SEL];
         digit_seen  <= 1'b0; // [RULE9]
      end else if (cmd[`CMD_EDIT_ENTER]) begin
         if (edit_active && digit_seen) begin
            preset[edit_sel] <= edit_buf; // [RULE8]
         end
         edit_active <= 1'b0;
      end else if (wr_en && paddr == `REG_EDIT) begin
         edit_buf   <= pwdata[15:0];
         digit_seen <= 1'b1; // [RULE9]
      end else if (wr_en && paddr == `REG_SHOT1) begin
         preset[0] <= pwdata[15:0]; // [RULE8]
      end else if (wr_en && paddr == `REG_SHOT2) begin
         preset[1] <= pwdata[15:0];
      end
   end

   // Main clock
   assign ld_any = cmd[`CMD_LD_PERIOD] | cmd[`CMD_LD_BREAK] | cmd[`CMD_LD_OT];
   assign main_done = ctrl[`CTRL_UP] ? (main_time >= main_limit) : (main_time == '0);

   always_comb begin
      if (cmd[`CMD_LD_PERIOD]) begin
         ld_len = period_len;
      end else if (cmd[`CMD_LD_BREAK]) begin
         ld_len = break_len; // [RULE6]
      end else begin
         ld_len = ot_len; // [RULE7]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_time  <= '0;
         main_limit <= '0;
         main_run   <= 1'b0;
         period_num <= '0;
      end else if (ld_any) begin
         main_time  <= ctrl[`CTRL_UP] ? '0 : ld_len; // [RULE2] [RULE3]
         main_limit <= ld_len;
         main_run   <= 1'b0;
         if (cmd[`CMD_LD_PERIOD] && main_time == '0) begin
            period_num <= period_num + 4'h1; // [RULE5]
         end
      end else begin
         if (cmd[`CMD_START] && !main_done) begin
            main_run <= 1'b1;
         end else if (cmd[`CMD_STOP]) begin
            main_run <= 1'b0;
         end else if (tick && main_run) begin
            if (ctrl[`CTRL_UP]) begin
               main_time <= main_time + 16'h0001; // [RULE3]
               if (main_time + 16'h0001 >= main_limit) begin
                  main_run <= 1'b0;
               end
            end else if (main_time != '0) begin
               main_time <= main_time - 16'h0001; // [RULE2]
               if (main_time == 16'h0001) begin
                  main_run <= 1'b0;
               end
            end else begin
               main_run <= 1'b0;
            end
         end
      end
   end

   // Shot clock
   assign blank_cond = ctrl[`CTRL_BLANK] && (shot_time >= main_time); // [RULE12]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shot_time <= '0;
         shot_run  <= 1'b0;
      end else if (blank_cond) begin
         shot_time <= preset[0]; // [RULE12]
         shot_run  <= 1'b0;
      end else begin
         if (rs.rise[0]) begin
            shot_time <= preset[0]; // [RULE8]
         end else if (rs.rise[1]) begin
            shot_time <= preset[1]; // [RULE8]
         end else if (tick && shot_run && shot_time != '0) begin
            shot_time <= shot_time - 16'h0001; // [RULE21]
         end
         if (!ctrl[`CTRL_SYNC]) begin
            shot_run <= rs.level[2] && shot_time != '0; // [RULE11]
         end else if (cmd[`CMD_STOP] && main_run && shot_run) begin
            shot_run <= 1'b0; // [RULE10]
         end else if (cmd[`CMD_START] && !main_done && shot_time != '0) begin
            shot_run <= 1'b1; // [RULE10]
         end else if (rs.rise[2] && shot_time != '0) begin
            shot_run <= 1'b1;
         end else if (!rs.level[2] && shot_run) begin
            shot_run <= 1'b0;
         end else if (tick && shot_time == 16'h0001) begin
            shot_run <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shot_horn_cnt <= '0;
         shot_horn     <= 1'b0;
      end else begin
         if (tick && shot_run && shot_time == 16'h0001 && !blank_cond) begin
            shot_horn_cnt <= 8'(HORN_TICKS);
         end else if (tick && shot_horn_cnt != '0) begin
            shot_horn_cnt <= shot_horn_cnt - 8'h01;
         end
         shot_horn <= shot_horn_cnt != '0;
      end
   end

   // Time-out timer
   assign to_active = to_state != game_clock_pkg::TO_IDLE;
   assign to_key    = cmd[`CMD_TO_HOME] | cmd[`CMD_TO_GUEST];
   assign to_idx    = {cmd[`CMD_TO_GUEST], cmd[`CMD_TO_PART]};
   assign to_dur    = cmd[`CMD_TO_PART] ? part_len : full_len; // [RULE16] [RULE18]
   assign to_warn   = (to_state == game_clock_pkg::TO_PART) ? partial_pause_alert_time
                                                            : full_warn;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_state <= game_clock_pkg::TO_IDLE;
         to_time  <= '0;
         for (int i = 0; i < 4; i++) begin
            to_count[i] <= `RST_COUNT;
         end
      end else begin
         case (to_state)
            game_clock_pkg::TO_IDLE: begin
               if (to_key && to_count[to_idx] != '0) begin // [RULE13]
                  to_time  <= to_dur;
                  to_count[to_idx] <= to_count[to_idx] - 8'h01; // [RULE22]
                  to_state <= cmd[`CMD_TO_PART] ? game_clock_pkg::TO_PART
                                                : game_clock_pkg::TO_FULL;
               end else if (cmd[`CMD_TO_ONOFF] && to_dur != '0) begin // [RULE14]
                  to_time  <= to_dur;
                  to_state <= cmd[`CMD_TO_PART] ? game_clock_pkg::TO_PART
                                                : game_clock_pkg::TO_FULL;
               end
            end
            game_clock_pkg::TO_FULL, game_clock_pkg::TO_PART: begin
               if (cmd[`CMD_TO_ONOFF] || to_time == '0) begin
                  to_state <= game_clock_pkg::TO_IDLE;
               end else if (tick) begin
                  to_time <= to_time - 16'h0001; // [RULE22]
                  if (to_time == 16'h0001) begin
                     to_state <= game_clock_pkg::TO_IDLE;
                  end
               end
            end
            default: begin
               to_state <= game_clock_pkg::TO_IDLE;
            end
         endcase
         // Counts only change by REG_TO_COUNTS write or time-out start
         if (wr_en && paddr == `REG_TO_COUNTS) begin
            for (int i = 0; i < 4; i++) begin
               to_count[i] <= pwdata[8*i +: 8]; // [RULE15]
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_horn_cnt  <= '0;
         timeout_horn <= 1'b0;
      end else begin
         if (tick && to_active && to_warn != '0
             && to_time == to_warn + 16'h0001) begin // [RULE17] [RULE19]
            to_horn_cnt <= 8'(HORN_TICKS);
         end else if (tick && to_horn_cnt != '0) begin
            to_horn_cnt <= to_horn_cnt - 8'h01;
         end
         timeout_horn <= to_horn_cnt != '0;
      end
   end

   // Display outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_digits    <= '0;
         main_tenths    <= 1'b0;
         game_quarters  <= 1'b0;
         shot_digits    <= '0;
         shot_blank     <= 1'b0;
         timeout_digits <= '0;
         lcd_value      <= '0;
      end else begin
         main_digits <= (to_active && ctrl[`CTRL_SHOW]) ? to_time : main_time; // [RULE20]
         main_tenths <= ctrl[`CTRL_TENTHS] && !ctrl[`CTRL_UP]
                        && (main_time < `MINUTE_TENTHS); // [RULE4]
         game_quarters  <= ctrl[`CTRL_FOUR]; // [RULE1]
         shot_digits    <= shot_time;
         shot_blank     <= blank_cond; // [RULE12]
         timeout_digits <= to_time;
         if (edit_active) begin
            lcd_value <= digit_seen ? edit_buf : preset[edit_sel]; // [RULE9]
         end else if (to_active) begin
            lcd_value <= to_time; // [RULE20]
         end else begin
            lcd_value <= main_time;
         end
      end
   end
endmodule // game_clock_timers
`default_nettype wire

// *** verilog/game_clock_cfg.svh ***
`ifndef GAME_CLOCK_CFG_SVH
`define GAME_CLOCK_CFG_SVH
`define CLK_PERIOD_NS   10
`define TICK_TIME_NS    100000000
`define HORN_TIME_NS    1000000000
`define MINUTE_TENTHS   16'h0258
`define RST_TIME        16'h0000
`define RST_CTRL        6'h00
`define RST_COUNT       8'h00
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_PERIOD      8'h08
`define REG_BREAK       8'h0c
`define REG_OVERTIME    8'h10
`define REG_SHOT1       8'h14
`define REG_SHOT2       8'h18
`define REG_FULL_LEN    8'h1c
`define REG_FULL_WARN   8'h20
`define REG_PART_LEN    8'h24
`define REG_PART_WARN   8'h28
`define REG_TO_COUNTS   8'h2c
`define REG_MAIN_STAT   8'h30
`define REG_SHOT_STAT   8'h34
`define REG_TO_STAT     8'h38
`define REG_EDIT        8'h3c
`define CTRL_FOUR       0
`define CTRL_UP         1
`define CTRL_TENTHS     2
`define CTRL_SYNC       3
`define CTRL_BLANK      4
`define CTRL_SHOW       5
`define CMD_START       0
`define CMD_STOP        1
`define CMD_LD_PERIOD   2
`define CMD_LD_BREAK    3
`define CMD_LD_OT       4
`define CMD_TO_HOME     5
`define CMD_TO_GUEST    6
`define CMD_TO_ONOFF    7
`define CMD_TO_PART     8
`define CMD_EDIT_BEGIN  9
`define CMD_EDIT_SEL    10
`define CMD_EDIT_ENTER  11
`define CMD_W           12
`endif

// *** verilog/game_clock_pkg.sv ***
package game_clock_pkg;
   typedef enum logic [2:0] {
      TO_IDLE = 3'b001,
      TO_FULL = 3'b010,
      TO_PART = 3'b100
   } to_state_e;
   typedef logic [15:0] time_t;
endpackage

// *** verilog/pin_sync_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if #(parameter int W = 3);
   logic [W-1:0] raw;
   logic [W-1:0] level;
   logic [W-1:0] rise;
   modport owner (output raw, input level, input rise);
   modport sync  (input raw, output level, output rise);
endinterface
`default_nettype wire

// *** verilog/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 3
) (
   input  wire logic    clk,
   input  wire logic    rst_n,
   pin_sync_if.sync     ps
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= ps.raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Level moves only when stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ps.level <= '0;
         ps.rise  <= '0;
      end else begin
         ps.level <= (s2 & s3) | (ps.level & (s2 | s3));
         ps.rise  <= s2 & s3 & ~ps.level;
      end
   end
endmodule // pin_sync
`default_nettype wire

// *** bench/game_clock_timers_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module game_clock_timers_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] main_digits,
   input wire logic        main_tenths,
   input wire logic [3:0]  period_num,
   input wire logic        game_quarters,
   input wire logic [15:0] shot_digits,
   input wire logic        shot_blank,
   input wire logic        shot_horn,
   input wire logic [15:0] timeout_digits,
   input wire logic        timeout_horn
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   access_ready_a: assert property (psel && penable |-> pready)
      else $error("no ready in access cycle");
   bad_addr_a: assert property (psel && !penable && paddr > 8'h3c |=> pslverr && pready)
      else $error("no error for unmapped address");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   quarters_wr_a: assert property (
      $changed(game_quarters) |-> $past(pready) || $past(pready, 2))
      else $error("structure changed without a write");
   period_step_a: assert property (
      $changed(period_num) |-> period_num == $past(period_num) + 4'h1)
      else $error("period number not stepped by one");
   blank_hold_a: assert property (shot_blank [*3] |-> $stable(shot_digits))
      else $error("blanked shot clock moving");
   blank_horn_a: assert property (shot_blank |-> !shot_horn)
      else $error("shot horn while blanked");
   tenths_under_a: assert property (
      main_tenths |-> main_digits < 16'h0258 || timeout_digits != 16'h0)
      else $error("tenths shown above one minute");
   horn_len_a: assert property ($rose(timeout_horn) |=> timeout_horn [*8])
      else $error("warning horn too short");
   cover property ($rose(shot_blank));
   cover property ($rose(timeout_horn));
   cover property ($changed(period_num));
endmodule // game_clock_timers_sva
bind game_clock_timers game_clock_timers_sva u_sva (.*);
`default_nettype wire

// *** bench/remote_console.sv ***
`timescale 1ns/100ps
`default_nettype none
module remote_console (
   input  wire logic clk,
   output logic      reset1,
   output logic      reset2,
   output logic      run
);
   initial begin
      reset1 = 1'b0;
      reset2 = 1'b0;
      run = 1'b0;
   end
   // Button held long enough to pass the pin filter
   task automatic press(input int which);
      @(posedge clk);
      if (which == 1)
         reset1 <= 1'b1;
      else
         reset2 <= 1'b1;
      repeat (6) @(posedge clk);
      reset1 <= 1'b0;
      reset2 <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic set_run(input logic v);
      @(posedge clk);
      run <= v;
      repeat (8) @(posedge clk);
   endtask
endmodule // remote_console
`default_nettype wire

// *** bench/tb_game_clock_timers.sv ***
`timescale 1ns/100ps
`include "game_clock_cfg.svh"
`default_nettype none
module tb_game_clock_timers;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic        pready, pslverr, remote_reset1, remote_reset2, remote_run, main_tenths;
   logic        game_quarters, shot_blank, shot_horn, timeout_horn, rd_err;
   logic [3:0]  period_num;
   logic [15:0] main_digits, shot_digits, timeout_digits, lcd_value, held;
   int          n_mismatch = 0, samples_checked = 0, cyc = 0, n;
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         stop_test();
      end
   end
   game_clock_timers #(.TICK_CYCLES(10)) u_dut (.*);
   remote_console u_rc (.clk(pclk), .reset1(remote_reset1), .reset2(remote_reset2),
      .run(remote_run));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic cmd(input int b, input logic p = 1'b0);
      bus(1'b1, `REG_CMD, (32'h1 << b) | {23'h0, p, 8'h0});
      repeat (3) @(posedge pclk);
   endtask
   task automatic tk(input int t);
      repeat (t * 10) @(posedge pclk);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h00000000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd_err, 1'b1, "unmapped err");
      bus(1'b0, `REG_CTRL, 32'h0);
      chk(rd_data, 32'h0, "ctrl reset");
      bus(1'b1, `REG_CTRL, 32'h5);
      tk(1);
      chk(game_quarters, 1'b1, "quarters");
      bus(1'b1, `REG_PERIOD, 32'h14);
      cmd(`CMD_LD_PERIOD);
      chk(period_num, 4'h1, "period");
      chk(main_digits, 16'h14, "down load");
      chk(main_tenths, 1'b1, "tenths");
      cmd(`CMD_LD_PERIOD);
      chk(period_num, 4'h1, "period kept");
      cmd(`CMD_START);
      tk(25);
      chk(main_digits, 16'h0, "down halt");
      bus(1'b1, `REG_CTRL, 32'h7);
      cmd(`CMD_LD_PERIOD);
      chk(period_num, 4'h2, "period next");
      chk(main_tenths, 1'b0, "tenths up");
      cmd(`CMD_START);
      tk(25);
      chk(main_digits, 16'h14, "up halt");
      bus(1'b1, `REG_CTRL, 32'h1);
      bus(1'b1, `REG_BREAK, 32'h32);
      cmd(`CMD_LD_BREAK);
      chk(main_digits, 16'h32, "break");
      bus(1'b1, `REG_OVERTIME, 32'h46);
      cmd(`CMD_LD_OT);
      chk(main_digits, 16'h46, "overtime");
      bus(1'b1, `REG_SHOT1, 32'h1e);
      bus(1'b1, `REG_SHOT2, 32'h2d);
      u_rc.press(2);
      chk(shot_digits, 16'h2d, "preset two");
      u_rc.press(1);
      chk(shot_digits, 16'h1e, "preset one");
      cmd(`CMD_EDIT_BEGIN);
      chk(lcd_value, 16'h1e, "edit view");
      bus(1'b1, `REG_EDIT, 32'h28);
      tk(1);
      chk(lcd_value, 16'h28, "edit digit");
      cmd(`CMD_EDIT_ENTER);
      u_rc.set_run(1'b1);
      tk(5);
      u_rc.set_run(1'b0);
      held = shot_digits;
      chk(held < 16'h1e, 1'b1, "shot ran");
      cmd(`CMD_START);
      tk(3);
      chk(shot_digits, held, "shot alone");
      bus(1'b1, `REG_CTRL, 32'h9);
      u_rc.set_run(1'b1);
      tk(2);
      cmd(`CMD_STOP);
      held = shot_digits;
      tk(3);
      chk(shot_digits, held, "sync stop");
      cmd(`CMD_START);
      tk(3);
      chk(shot_digits < held, 1'b1, "sync run");
      u_rc.set_run(1'b0);
      bus(1'b1, `REG_BREAK, 32'ha);
      cmd(`CMD_LD_BREAK);
      bus(1'b1, `REG_CTRL, 32'h11);
      tk(1);
      chk(shot_blank, 1'b1, "blank");
      chk(shot_digits, 16'h28, "blank load");
      bus(1'b1, `REG_CTRL, 32'h21);
      bus(1'b1, `REG_FULL_LEN, 32'h1e);
      bus(1'b1, `REG_FULL_WARN, 32'h14);
      bus(1'b1, `REG_TO_COUNTS, 32'h1);
      cmd(`CMD_TO_HOME);
      chk(timeout_digits, 16'h1e, "full");
      chk(main_digits, 16'h1e, "on main");
      bus(1'b0, `REG_TO_COUNTS, 32'h0);
      chk(rd_data, 32'h0, "count used");
      n = 0;
      while (timeout_horn !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk(timeout_digits, 16'h14, "warn");
      tk(9);
      chk(timeout_horn, 1'b1, "horn on");
      tk(2);
      chk(timeout_horn, 1'b0, "horn off");
      tk(20);
      chk(timeout_digits, 16'h0, "to halt");
      cmd(`CMD_TO_HOME);
      chk(timeout_digits, 16'h0, "no count");
      cmd(`CMD_TO_ONOFF, 1'b1);
      chk(timeout_digits, 16'h0, "zero len");
      bus(1'b0, `REG_TO_STAT, 32'h0);
      chk(rd_data, 32'h00010000, "off idle");
      bus(1'b1, `REG_PART_LEN, 32'h14);
      bus(1'b1, `REG_TO_COUNTS, 32'h1000000);
      cmd(`CMD_TO_GUEST, 1'b1);
      chk(timeout_digits, 16'h14, "partial");
      tk(25);
      chk(timeout_horn, 1'b0, "no warn");
      chk(timeout_digits, 16'h0, "part halt");
      cmd(`CMD_TO_ONOFF, 1'b1);
      bus(1'b0, `REG_TO_STAT, 32'h0);
      chk(rd_data & 32'h00070000, 32'h00040000, "on/off part");
      bus(1'b1, `REG_SHOT1, 32'h3);
      u_rc.press(1);
      u_rc.set_run(1'b1);
      tk(4);
      chk(shot_horn, 1'b1, "shot horn");
      stop_test();
   end
endmodule // tb_game_clock_timers
`default_nettype wire
